/* core/idc_idle_ctrl.sv */
// Idle domain control with AXI4-Lite register access
module idc_idle_ctrl #(
	parameter int PERIPH_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [idc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [idc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic idle_exec,
	input wire logic wake_req,
	output idc_pkg::idc_dom_t dom_idle,
	output logic [PERIPH_W-1:0] periph_disable,
	output logic bus_err_int,
	output logic irq
);
	import idc_pkg::*;

	// Register index from a byte address; unaligned or out of range gives zero
	function automatic logic [3:0] addr_idx(input logic [ADDR_W-1:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a[1:0] == 2'h0 && a[ADDR_W-1:6] == '0) begin
			r = a[5:2];
		end
		return r;
	endfunction

	function automatic logic idx_mapped(input logic [3:0] i);
		logic m;
		m = (i == IDX_CFG) || (i == IDX_STS) || (i == IDX_PSEL)
			|| (i == IDX_INT_STS) || (i == IDX_INT_MASK);
		return m;
	endfunction

	// Byte-lane merge into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [15:0] wmask);
		logic [15:0] n;
		n = old;
		if (strb[0]) begin
			n[7:0] = d[7:0];
		end
		if (strb[1]) begin
			n[15:8] = d[15:8];
		end
		return (n & wmask) | (old & ~wmask);
	endfunction

	// Bus state
	logic aw_have_q;
	logic aw_have_d;
	logic w_have_q;
	logic w_have_d;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;

	// Block state
	idc_cfg_t cfg_q;
	idc_dom_t dom_q;
	logic [PERIPH_W-1:0] psel_q;
	logic [PERIPH_W-1:0] periph_off_q;
	logic [PERIPH_W-1:0] periph_off_d;
	logic [EV_W-1:0] int_sts_q;
	logic [EV_W-1:0] int_sts_d;
	logic [EV_W-1:0] int_mask_q;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] int_clr;
	logic bus_err_q;
	logic irq_q;
	logic idle_err;
	logic wake_only;
	logic [15:0] cfg_wr;
	logic [15:0] psel_wr;

	// Check results
	logic chk_pair_err;
	logic chk_deps_err;
	logic chk_err;
	idc_dom_t chk_dom;

	idc_check u_check (
		.cfg(cfg_q),
		.clk_pair_err(chk_pair_err),
		.clk_deps_err(chk_deps_err),
		.bus_err(chk_err),
		.dom_next(chk_dom)
	);

	// Error seen at an idle instruction; clock idle is suppressed then
	assign idle_err = idle_exec && chk_err;
	// A wake in the same cycle as an idle instruction loses
	assign wake_only = wake_req && !idle_exec;

	// Write channel bookkeeping
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
		end
	end

	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_idx = addr_idx(awaddr_q);
	assign rd_idx = addr_idx(s_axi_araddr);

	// Write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awready_q <= 1'b0;
			awaddr_q <= '0;
		end else begin
			aw_have_q <= aw_have_d;
			awready_q <= !aw_have_d;
			if (s_axi_awvalid && awready_q) begin
				awaddr_q <= s_axi_awaddr;
			end
		end
	end

	// Write data capture, either order with the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wready_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			w_have_q <= w_have_d;
			wready_q <= !w_have_d;
			if (s_axi_wvalid && wready_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign cfg_wr = merge16({6'h00, cfg_q}, wdata_q, wstrb_q, CFG_WMASK);
	assign psel_wr = merge16(16'(psel_q), wdata_q, wstrb_q, PSEL_WMASK);

	// Configuration register; a write only stores requests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= idc_cfg_t'(CFG_RST);
		end else if (wr_fire && wr_idx == IDX_CFG) begin
			cfg_q <= idc_cfg_t'(cfg_wr[9:0]);
		end
	end

	// Peripheral select register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psel_q <= PERIPH_W'(PSEL_RST);
		end else if (wr_fire && wr_idx == IDX_PSEL) begin
			psel_q <= PERIPH_W'(psel_wr);
		end
	end

	// Interrupt mask register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_mask_q <= INT_RST;
		end else if (wr_fire && wr_idx == IDX_INT_MASK && wstrb_q[0]) begin
			int_mask_q <= wdata_q[EV_W-1:0];
		end
	end

	// Domain state changes only at the idle instruction or a wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dom_q <= idc_dom_t'(DOM_RST);
		end else if (idle_exec) begin
			dom_q <= chk_dom;
		end else if (wake_req) begin
			dom_q <= idc_dom_t'(DOM_RST);
		end
	end

	// Next disable per peripheral: its select bit ANDed with periph_idle_req at idle, cleared by a wake
	for (genvar p = 0; p < PERIPH_W; p++) begin : g_periph
		assign periph_off_d[p] = idle_exec ? (cfg_q.periph_idle_req & psel_q[p])
			: (wake_req ? 1'b0 : periph_off_q[p]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_off_q <= '0;
		end else begin
			periph_off_q <= periph_off_d;
		end
	end

	// Bus error interrupt pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_err_q <= 1'b0;
		end else begin
			bus_err_q <= idle_err;
		end
	end

	// Sticky event flags, write one to clear, set wins
	always_comb begin
		events = '0;
		events[EV_BUS_ERR] = idle_err;
		events[EV_IDLE] = idle_exec;
		events[EV_WAKE] = wake_only;
		int_clr = '0;
		if (wr_fire && wr_idx == IDX_INT_STS && wstrb_q[0]) begin
			int_clr = wdata_q[EV_W-1:0];
		end
		int_sts_d = (int_sts_q & ~int_clr) | events;
	end

	// Status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_sts_q <= INT_RST;
		end else begin
			int_sts_q <= int_sts_d;
		end
	end

	// Level interrupt from the next status, so it rises with the flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_sts_d & int_mask_q);
		end
	end

	// Read channel
	always_comb begin
		rvalid_d = rvalid_q;
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			rvalid_q <= rvalid_d;
			arready_q <= !rvalid_d;
		end
	end

	// Read data, captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
			case (rd_idx)
				IDX_CFG: begin
					rdata_q <= {22'h0, cfg_q};
				end
				IDX_STS: begin
					rdata_q <= {23'h0, dom_q};
				end
				IDX_PSEL: begin
					rdata_q <= 32'(psel_q);
				end
				IDX_INT_STS: begin
					rdata_q <= {29'h0, int_sts_q};
				end
				IDX_INT_MASK: begin
					rdata_q <= {29'h0, int_mask_q};
				end
				default: begin
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign dom_idle = dom_q;
	assign periph_disable = periph_off_q;
	assign bus_err_int = bus_err_q;
	assign irq = irq_q;

endmodule // idc_idle_ctrl

/* shared/idc_pkg.sv */
// Package of constants and types for the idle domain control block
package idc_pkg;

	localparam int ADDR_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_CFG = 4'h1;
	localparam logic [3:0] IDX_STS = 4'h2;
	localparam logic [3:0] IDX_PSEL = 4'h3;
	localparam logic [3:0] IDX_INT_STS = 4'h4;
	localparam logic [3:0] IDX_INT_MASK = 4'h5;

	// Writable bits
	localparam logic [15:0] CFG_WMASK = 16'h03ff;
	localparam logic [15:0] PSEL_WMASK = 16'h3fef;

	// Reset values
	localparam logic [9:0] CFG_RST = 10'h000;
	localparam logic [8:0] DOM_RST = 9'h000;
	localparam logic [15:0] PSEL_RST = 16'h0000;
	localparam logic [2:0] INT_RST = 3'h0;

	// Event bit positions
	localparam int EV_BUS_ERR = 0;
	localparam int EV_IDLE = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_W = 3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Idle configuration layout, bits 9..0
	typedef struct packed {
		logic clkgen_idle_ext;
		logic instr_port_idle_req;
		logic master_port_idle_req;
		logic io_port_idle_req;
		logic ext_mem_if_idle_req;
		logic clkgen_idle_req;
		logic periph_idle_req;
		logic instr_cache_idle_req;
		logic master_periph_idle_req;
		logic core_idle_req;
	} idc_cfg_t;

	// Domain idle state, bits 8..0, same order as status register
	typedef struct packed {
		logic instr_port_off;
		logic master_port_off;
		logic io_port_off;
		logic ext_mem_if_off;
		logic clkgen_off;
		logic periph_off;
		logic instr_cache_off;
		logic dma_host_port_off;
		logic core_off;
	} idc_dom_t;

endpackage

/* core/idc_check.sv */
// Validity check and domain targets for an idle instruction
module idc_check (
	input idc_pkg::idc_cfg_t cfg,
	output logic clk_pair_err,
	output logic clk_deps_err,
	output logic bus_err,
	output idc_pkg::idc_dom_t dom_next
);
	import idc_pkg::*;

	logic deps_set;

	always_comb begin
		deps_set = cfg.clkgen_idle_ext & cfg.core_idle_req & cfg.master_periph_idle_req
			& cfg.instr_cache_idle_req & cfg.ext_mem_if_idle_req & cfg.io_port_idle_req
			& cfg.master_port_idle_req & cfg.instr_port_idle_req;
		clk_pair_err = cfg.clkgen_idle_req & ~cfg.clkgen_idle_ext;
		clk_deps_err = cfg.clkgen_idle_req & ~deps_set;
		bus_err = clk_pair_err | clk_deps_err;
		dom_next.instr_port_off = cfg.instr_port_idle_req;
		dom_next.master_port_off = cfg.master_port_idle_req;
		dom_next.io_port_off = cfg.io_port_idle_req;
		dom_next.ext_mem_if_off = cfg.ext_mem_if_idle_req;
		// Clock stops only for a fully valid deep setting
		dom_next.clkgen_off = cfg.clkgen_idle_req & cfg.clkgen_idle_ext & ~bus_err;
		dom_next.periph_off = cfg.periph_idle_req;
		dom_next.instr_cache_off = cfg.instr_cache_idle_req;
		dom_next.dma_host_port_off = cfg.master_periph_idle_req;
		dom_next.core_off = cfg.core_idle_req;
	end

endmodule // idc_check

/* verif/idc_idle_ctrl_checker.sv */
// Port checker for the idle domain controller
module idc_checker
	import idc_pkg::*;
#(
	parameter int PERIPH_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic idle_exec,
	input wire logic wake_req,
	input wire idc_pkg::idc_dom_t dom_idle,
	input wire logic [PERIPH_W-1:0] periph_disable,
	input wire logic bus_err_int
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_hold;
		!idle_exec && !wake_req |=> $stable(dom_idle) && $stable(periph_disable);
	endproperty
	a_hold: assert property (p_hold) else $error("domains moved without idle");
	property p_wake;
		wake_req && !idle_exec |=> dom_idle == '0 && periph_disable == '0;
	endproperty
	a_wake: assert property (p_wake) else $error("wake left a domain off");
	property p_err_src;
		bus_err_int |-> $past(idle_exec);
	endproperty
	a_err_src: assert property (p_err_src) else $error("bus error without idle");
	property p_err_noclk;
		bus_err_int |-> !dom_idle.clkgen_off;
	endproperty
	a_err_noclk: assert property (p_err_noclk) else $error("clock idled on error");
	property p_clk_deps;
		dom_idle.clkgen_off |-> &{dom_idle.core_off, dom_idle.dma_host_port_off,
			dom_idle.instr_cache_off, dom_idle.ext_mem_if_off, dom_idle.io_port_off,
			dom_idle.master_port_off, dom_idle.instr_port_off};
	endproperty
	a_clk_deps: assert property (p_clk_deps) else $error("clock off, domain on");
	property p_per_off;
		!dom_idle.periph_off |-> periph_disable == '0;
	endproperty
	a_per_off: assert property (p_per_off) else $error("peripheral off");
	property p_err_pulse;
		bus_err_int && !idle_exec |=> !bus_err_int;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("bus error too long");
	property p_rst;
		$rose(aresetn) |-> dom_idle == '0 && periph_disable == '0 && !bus_err_int;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear at reset");
	property p_clk_exec;
		$rose(dom_idle.clkgen_off) |-> $past(idle_exec);
	endproperty
	a_clk_exec: assert property (p_clk_exec) else $error("clock off without idle");
	c_err: cover property (bus_err_int);
	c_clk: cover property (dom_idle.clkgen_off);
	c_wake: cover property (wake_req ##1 dom_idle == '0);
endmodule // idc_checker

bind idc_idle_ctrl idc_checker #(.PERIPH_W(PERIPH_W)) idc_checker_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.idle_exec(idle_exec),
	.wake_req(wake_req),
	.dom_idle(dom_idle),
	.periph_disable(periph_disable),
	.bus_err_int(bus_err_int)
);

/* verif/tb_idle_domain_control.sv */
// Testbench for the idle domain controller
module tb_idle_domain_control;
	timeunit 1ns;
	timeprecision 1ns;
	import idc_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic idle_exec = 0, wake_req = 0, ie_q = 0, msk = 0, st0 = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rnd;
	logic awready, wready, bvalid, arready, rvalid, bus_err_int, irq;
	logic [1:0] bresp, rresp;
	idc_dom_t dom_idle;
	logic [15:0] periph_disable, psel = 0;
	logic [9:0] c;
	logic [9:0] tbl [6] = '{10'h3f7, 10'h010, 10'h200, 10'h3d7, 10'h008, 10'h3ff};
	int error_cnt = 0, comparisons = 0, seed = 32'h1e3f518a;
	logic [1:0] eb[$];
	logic [33:0] er[$];
	logic [26:0] ei[$];

	always #25 aclk = ~aclk;

	idc_idle_ctrl #(.PERIPH_W(16)) idc_idle_ctrl_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(1'h1),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(1'h1),
		.idle_exec(idle_exec),
		.wake_req(wake_req),
		.dom_idle(dom_idle),
		.periph_disable(periph_disable),
		.bus_err_int(bus_err_int),
		.irq(irq)
	);

	task automatic cmp_idle(input logic [26:0] e, input logic [26:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED idle exp %h got %h", e, g);
		end
	endtask

	task automatic cmp_bresp(input logic [1:0] e, input logic [1:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED bresp exp %h got %h", e, g);
		end
	endtask

	task automatic cmp_read(input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED read exp %h got %h", e, g);
		end
	endtask

	task print_verdict;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ao, wo;
		ao = 0;
		wo = 0;
		eb.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(ao && wo)) begin
			@(posedge aclk);
			if (awready && !ao) begin
				ao = 1;
				awvalid <= 1'h0;
			end
			if (wready && !wo) begin
				wo = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		er.push_back({r, d});
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
	endtask

	// Expected outcome of an idle instruction or a wake
	task automatic idl(input logic [9:0] k, input logic w);
		logic ok, e;
		idc_dom_t d;
		ok = k[4] & (&k[9:5]) & (&k[2:0]);
		d = w ? '0 : k[8:0];
		d.clkgen_off = ok & !w;
		e = k[4] & !ok & !w;
		st0 = st0 | e;
		ei.push_back({msk & st0, e, (k[3] & !w) ? psel : 16'h0, d});
		if (w) wake_req <= 1'h1;
		else idle_exec <= 1'h1;
		@(posedge aclk);
		idle_exec <= 1'h0;
		wake_req <= 1'h0;
		@(posedge aclk);
	endtask

	always @(posedge aclk) begin
		if (ie_q) cmp_idle(ei.pop_front(), {irq, bus_err_int, periph_disable, dom_idle});
		if (bvalid) cmp_bresp(eb.pop_front(), bresp);
		if (rvalid) cmp_read(er.pop_front(), {rresp, rdata});
		ie_q = aresetn & (idle_exec | wake_req);
	end

	initial begin
		#(50 * 4000);
		error_cnt++;
		print_verdict;
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(8'h04, 32'h0, RESP_OKAY);
		rd(8'h0c, 32'h0, RESP_OKAY);
		wr(8'h04, 32'hffffffff, RESP_OKAY);
		rd(8'h04, 32'h3ff, RESP_OKAY);
		wr(8'h08, 32'hffffffff, RESP_OKAY);
		rd(8'h08, 32'h0, RESP_OKAY);
		rd(8'h3c, 32'h0, RESP_SLVERR);
		wr(8'h3c, 32'h1, RESP_SLVERR);
		wr(8'h14, 32'h1, RESP_OKAY);
		msk = 1;
		for (int i = 0; i < 20; i++) begin
			c = (i < 6) ? tbl[i] : 10'($random(seed));
			rnd = $random(seed);
			psel = rnd[15:0] & PSEL_WMASK;
			wr(8'h04, {22'h0, c}, RESP_OKAY);
			wr(8'h0c, {16'h0, rnd[15:0]}, RESP_OKAY);
			idl(c, 1'h0);
			if (i % 4 == 3) idl(c, 1'h1);
		end
		wr(8'h10, 32'h7, RESP_OKAY);
		st0 = 0;
		wr(8'h04, 32'h10, RESP_OKAY);
		idl(10'h010, 1'h0);
		rd(8'h10, 32'h3, RESP_OKAY);
		wr(8'h10, 32'h7, RESP_OKAY);
		wr(8'h14, 32'h0, RESP_OKAY);
		msk = 0;
		st0 = 0;
		idl(10'h010, 1'h0);
		print_verdict;
	end
endmodule // tb_idle_domain_control
